// ===== mqcs_defines.vh
// constants for the message queue control and status block
`ifndef MQCS_DEFINES_VH
`define MQCS_DEFINES_VH

// register byte offsets
`define MQCS_OFF_CTRL_STAT     12'h508
`define MQCS_OFF_IFL_BOT       12'h510
`define MQCS_OFF_IFL_TOP       12'h514
`define MQCS_OFF_IPL_BOT       12'h518
`define MQCS_OFF_IPL_TOP       12'h51c
`define MQCS_OFF_OFL_BOT       12'h520
`define MQCS_OFF_OFL_TOP       12'h524
`define MQCS_OFF_PROC_OUT_IDX  12'h528

// control/status field positions
`define MQCS_BIT_SHELL_EN      0
`define MQCS_BIT_EXT_OUT_EN    1
`define MQCS_BIT_IPL_NONEMPTY  2
`define MQCS_BIT_OFL_NONEMPTY  3
`define MQCS_BIT_EMPTY_SEL     4
`define MQCS_SIZE_LSB          5
`define MQCS_SIZE_MSB          7

// reset values
`define MQCS_RST_SIZE          3'h0
`define MQCS_RST_PTR           18'h00000
`define MQCS_RST_IDX           14'h0000

// widths
`define MQCS_PTR_W             18
`define MQCS_IDX_W             14
`define MQCS_NQ                3

// queue numbering inside the pointer arrays
`define MQCS_Q_IFL             0
`define MQCS_Q_IPL             1
`define MQCS_Q_OFL             2

// host outbound post list size codes
`define MQCS_SIZE_1K_ENT       3'h2
`define MQCS_SIZE_4K_ENT       3'h4

// index bits that step, per size (4-byte entries)
`define MQCS_MASK_256          14'h03fc
`define MQCS_MASK_1K           14'h0ffc
`define MQCS_MASK_4K           14'h3ffc

// pointer step and empty-read answer
`define MQCS_PTR_STEP          18'h00004
`define MQCS_IDX_STEP          14'h0004
`define MQCS_ALL_ONES          32'hffffffff

`endif

// ===== mqcs_queue.v
// one circular queue: bottom and top pointers with empty compare
`timescale 1ns/1ns
`include "mqcs_defines.vh"

module mqcs_queue (
	// clock and reset
	input  wire                    mclk,
	input  wire                    rst,
	// software writes
	input  wire                    wr_bot,
	input  wire                    wr_top,
	input  wire [`MQCS_PTR_W-1:0]  wdata,
	// hardware advances
	input  wire                    inc_bot,
	input  wire                    inc_top,
	// pointer state
	output reg  [`MQCS_PTR_W-1:0]  bot_q,
	output reg  [`MQCS_PTR_W-1:0]  top_q,
	output wire                    empty
);

	reg [`MQCS_PTR_W-1:0] bot_d;   // next bottom
	reg [`MQCS_PTR_W-1:0] top_d;   // next top

	// next pointers; a software write wins over a same-cycle advance
	always @* begin
		bot_d = bot_q;
		top_d = top_q;
		if (wr_bot) begin
			bot_d = {wdata[`MQCS_PTR_W-1:2], 2'b00};
		end else if (inc_bot) begin
			bot_d = bot_q + `MQCS_PTR_STEP;
		end
		if (wr_top) begin
			top_d = {wdata[`MQCS_PTR_W-1:2], 2'b00};
		end else if (inc_top) begin
			top_d = top_q + `MQCS_PTR_STEP;
		end
	end

	// pointer flops
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			bot_q <= `MQCS_RST_PTR;
			top_q <= `MQCS_RST_PTR;
		end else begin
			bot_q <= bot_d;
			top_q <= top_d;
		end
	end

	// equal pointers mean nothing queued
	assign empty = (bot_q == top_q);

endmodule // mqcs_queue

// ===== mqcs_top.v
// message queue control/status register bank with its queue pointers
`timescale 1ns/1ns
`include "mqcs_defines.vh"

// How it works
// - select set: empty inbound post or outbound free bottom read gives ones
// - select clear: empty bottom read gives pointer
// - outbound free flag shows frames available
// - inbound post flag shows frames waiting
// - size code picks capacity and stepping bits
// - equal bottom and top means empty
// - inbound free bottom steps four per read
module mqcs_top (
	// clock and reset
	input  wire        mclk,
	input  wire        rst,
	// register port
	input  wire [11:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata_q,
	// primary pci side events
	input  wire        pci_target_hit,
	input  wire        pci_inbound_read,
	input  wire        pci_inbound_post,
	input  wire        pci_outbound_free,
	input  wire        host_outbound_post,
	output reg         pci_retry_q,
	// status and control levels
	output reg         shell_interface_enable_q,
	output reg         extended_outbound_enable_q,
	output reg         inbound_post_nonempty_q,
	output reg         outbound_free_nonempty_q
);

	////////////////////////////////////////////////////////////////////
	// state

	reg  [2:0]                         host_outbound_post_size_q;   // size code
	reg                                empty_read_response_sel_q;   // ones on empty
	reg  [`MQCS_IDX_W-1:0]             processor_outbound_index_q;  // host index
	reg  [`MQCS_IDX_W-1:0]             out_idx_d;                   // next index
	reg  [`MQCS_IDX_W-1:0]             step_mask;                   // bits that step
	reg  [31:0]                        rdata_d;                     // next read data
	wire [`MQCS_NQ*`MQCS_PTR_W-1:0]    bot_all;                     // bottoms packed
	wire [`MQCS_NQ*`MQCS_PTR_W-1:0]    top_all;                     // tops packed
	wire [`MQCS_NQ-1:0]                q_empty;                     // per queue
	wire [`MQCS_NQ-1:0]                wr_bot;                      // bottom writes
	wire [`MQCS_NQ-1:0]                wr_top;                      // top writes
	wire [`MQCS_NQ-1:0]                inc_bot;                     // bottom advance
	wire [`MQCS_NQ-1:0]                inc_top;                     // top advance
	wire                               wr_ctrl;                     // ctrl write
	wire                               wr_idx;                      // index write

	////////////////////////////////////////////////////////////////////
	// address decode

	assign wr_ctrl = reg_wr && (reg_addr == `MQCS_OFF_CTRL_STAT);
	assign wr_idx  = reg_wr && (reg_addr == `MQCS_OFF_PROC_OUT_IDX);

	assign wr_bot[`MQCS_Q_IFL] = reg_wr && (reg_addr == `MQCS_OFF_IFL_BOT);
	assign wr_top[`MQCS_Q_IFL] = reg_wr && (reg_addr == `MQCS_OFF_IFL_TOP);
	assign wr_bot[`MQCS_Q_IPL] = reg_wr && (reg_addr == `MQCS_OFF_IPL_BOT);
	assign wr_top[`MQCS_Q_IPL] = reg_wr && (reg_addr == `MQCS_OFF_IPL_TOP);
	assign wr_bot[`MQCS_Q_OFL] = reg_wr && (reg_addr == `MQCS_OFF_OFL_BOT);
	assign wr_top[`MQCS_Q_OFL] = reg_wr && (reg_addr == `MQCS_OFF_OFL_TOP);

	////////////////////////////////////////////////////////////////////
	// hardware pointer movement

	// pci reads consume inbound free frames; pci posts and frees fill tops
	assign inc_bot[`MQCS_Q_IFL] = pci_inbound_read;
	assign inc_top[`MQCS_Q_IFL] = 1'b0;
	assign inc_bot[`MQCS_Q_IPL] = 1'b0;
	assign inc_top[`MQCS_Q_IPL] = pci_inbound_post;
	assign inc_bot[`MQCS_Q_OFL] = 1'b0;
	assign inc_top[`MQCS_Q_OFL] = pci_outbound_free;

	////////////////////////////////////////////////////////////////////
	// queues, one per entry of the pointer arrays

	genvar gi;
	generate
		for (gi = 0; gi < `MQCS_NQ; gi = gi + 1) begin : g_q
			mqcs_queue u_queue (
				.mclk    (mclk),
				.rst     (rst),
				.wr_bot  (wr_bot[gi]),
				.wr_top  (wr_top[gi]),
				.wdata   (reg_wdata[`MQCS_PTR_W-1:0]),
				.inc_bot (inc_bot[gi]),
				.inc_top (inc_top[gi]),
				.bot_q   (bot_all[gi*`MQCS_PTR_W +: `MQCS_PTR_W]),
				.top_q   (top_all[gi*`MQCS_PTR_W +: `MQCS_PTR_W]),
				.empty   (q_empty[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// control fields

	// writable bits of the control/status word; status bits ignore writes
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			shell_interface_enable_q   <= 1'b0;
			extended_outbound_enable_q <= 1'b0;
			empty_read_response_sel_q  <= 1'b0;
			host_outbound_post_size_q  <= `MQCS_RST_SIZE;
		end else if (wr_ctrl) begin
			// enable order versus queue setup is software's job
			shell_interface_enable_q   <= reg_wdata[`MQCS_BIT_SHELL_EN];
			extended_outbound_enable_q <= reg_wdata[`MQCS_BIT_EXT_OUT_EN];
			empty_read_response_sel_q  <= reg_wdata[`MQCS_BIT_EMPTY_SEL];
			// all codes are stored so software reads back what it wrote
			host_outbound_post_size_q  <= reg_wdata[`MQCS_SIZE_MSB:`MQCS_SIZE_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags

	// registered compare keeps the outputs flop-driven; one cycle of lag
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			inbound_post_nonempty_q  <= 1'b0;
			outbound_free_nonempty_q <= 1'b0;
		end else begin
			inbound_post_nonempty_q  <= ~q_empty[`MQCS_Q_IPL];
			outbound_free_nonempty_q <= ~q_empty[`MQCS_Q_OFL];
		end
	end

	////////////////////////////////////////////////////////////////////
	// target image retry

	// while the shell is off every hit on the image is answered with retry
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pci_retry_q <= 1'b0;
		end else begin
			pci_retry_q <= pci_target_hit && !shell_interface_enable_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// host outbound index stepping

	// size code selects which index bits wrap; reserved codes fall to 256
	always @* begin
		case (host_outbound_post_size_q)
			`MQCS_SIZE_1K_ENT: step_mask = `MQCS_MASK_1K;
			`MQCS_SIZE_4K_ENT: step_mask = `MQCS_MASK_4K;
			default:           step_mask = `MQCS_MASK_256;
		endcase
	end

	// index steps by one entry within its window; bits outside stay put
	always @* begin
		out_idx_d = processor_outbound_index_q;
		if (wr_idx) begin
			// software seeds the index when it turns the extension on
			out_idx_d = {reg_wdata[`MQCS_IDX_W-1:2], 2'b00};
		end else if (host_outbound_post && extended_outbound_enable_q) begin
			out_idx_d = (processor_outbound_index_q & ~step_mask) |
				((processor_outbound_index_q + `MQCS_IDX_STEP) & step_mask);
		end
	end

	// index flop
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			processor_outbound_index_q <= `MQCS_RST_IDX;
		end else begin
			processor_outbound_index_q <= out_idx_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data

	// read mux; unmapped addresses and idle cycles give zero
	always @* begin
		rdata_d = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				`MQCS_OFF_CTRL_STAT: begin
					// upper bits are reserved and read zero
					rdata_d[`MQCS_BIT_SHELL_EN]             = shell_interface_enable_q;
					rdata_d[`MQCS_BIT_EXT_OUT_EN]           = extended_outbound_enable_q;
					rdata_d[`MQCS_BIT_IPL_NONEMPTY]         = inbound_post_nonempty_q;
					rdata_d[`MQCS_BIT_OFL_NONEMPTY]         = outbound_free_nonempty_q;
					rdata_d[`MQCS_BIT_EMPTY_SEL]            = empty_read_response_sel_q;
					rdata_d[`MQCS_SIZE_MSB:`MQCS_SIZE_LSB]  = host_outbound_post_size_q;
				end
				`MQCS_OFF_IFL_BOT: begin
					rdata_d[`MQCS_PTR_W-1:0] = bot_all[`MQCS_Q_IFL*`MQCS_PTR_W +: `MQCS_PTR_W];
				end
				`MQCS_OFF_IFL_TOP: begin
					rdata_d[`MQCS_PTR_W-1:0] = top_all[`MQCS_Q_IFL*`MQCS_PTR_W +: `MQCS_PTR_W];
				end
				`MQCS_OFF_IPL_BOT: begin
					// compare is live so the answer matches this very cycle
					if (q_empty[`MQCS_Q_IPL] && empty_read_response_sel_q) begin
						rdata_d = `MQCS_ALL_ONES;
					end else begin
						rdata_d[`MQCS_PTR_W-1:0] =
							bot_all[`MQCS_Q_IPL*`MQCS_PTR_W +: `MQCS_PTR_W];
					end
				end
				`MQCS_OFF_IPL_TOP: begin
					rdata_d[`MQCS_PTR_W-1:0] = top_all[`MQCS_Q_IPL*`MQCS_PTR_W +: `MQCS_PTR_W];
				end
				`MQCS_OFF_OFL_BOT: begin
					if (q_empty[`MQCS_Q_OFL] && empty_read_response_sel_q) begin
						rdata_d = `MQCS_ALL_ONES;
					end else begin
						rdata_d[`MQCS_PTR_W-1:0] =
							bot_all[`MQCS_Q_OFL*`MQCS_PTR_W +: `MQCS_PTR_W];
					end
				end
				`MQCS_OFF_OFL_TOP: begin
					rdata_d[`MQCS_PTR_W-1:0] = top_all[`MQCS_Q_OFL*`MQCS_PTR_W +: `MQCS_PTR_W];
				end
				`MQCS_OFF_PROC_OUT_IDX: begin
					rdata_d[`MQCS_IDX_W-1:0] = processor_outbound_index_q;
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
	end

	// read data stands for exactly the cycle after the strobe
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 32'h00000000;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end

endmodule // mqcs_top

// ===== mqcs_properties.sv
// port assertions for the message queue control and status bank
`timescale 1ns/1ns
module mqcs_properties (
	// clock and reset
	input wire        mclk,
	input wire        rst,
	// register port
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata_q,
	// host events and levels
	input wire        pci_target_hit,
	input wire        pci_inbound_post,
	input wire        pci_outbound_free,
	input wire        pci_retry_q,
	input wire        shell_interface_enable_q,
	input wire        extended_outbound_enable_q,
	input wire        inbound_post_nonempty_q,
	input wire        outbound_free_nonempty_q
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_retry; pci_target_hit && !shell_interface_enable_q |=> pci_retry_q; endproperty
	a_retry: assert property (p_retry) else $error("hit while disabled not retried");
	property p_retry_cause;
		pci_retry_q |-> $past(pci_target_hit) && !$past(shell_interface_enable_q);
	endproperty
	a_retry_cause: assert property (p_retry_cause) else $error("retry without cause");
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
	property p_ctrl_read;
		$past(reg_rd) && $past(reg_addr) == 12'h508 |-> reg_rdata_q[31:8] == 24'h0 &&
		reg_rdata_q[1:0] == {$past(extended_outbound_enable_q), $past(shell_interface_enable_q)};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control word read wrong");
	property p_ctrl_wr;
		reg_wr && reg_addr == 12'h508 |=> {extended_outbound_enable_q, shell_interface_enable_q}
		== $past(reg_wdata[1:0]);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("enable bits not written");
	// flags lag the pointer move by one cycle, so the cause sits two edges back
	property p_ipl_rise; $rose(inbound_post_nonempty_q) |-> $past(pci_inbound_post, 2) ||
		$past(reg_wr, 2); endproperty
	a_ipl_rise: assert property (p_ipl_rise) else $error("inbound flag rose alone");
	property p_ofl_rise; $rose(outbound_free_nonempty_q) |-> $past(pci_outbound_free, 2) ||
		$past(reg_wr, 2); endproperty
	a_ofl_rise: assert property (p_ofl_rise) else $error("outbound flag rose alone");
	property p_ipl_fall; $fell(inbound_post_nonempty_q) |-> $past(reg_wr, 2); endproperty
	a_ipl_fall: assert property (p_ipl_fall) else $error("inbound flag fell alone");
	c_retry: cover property (pci_retry_q);
	c_ones: cover property ($past(reg_rd) && reg_rdata_q == 32'hffffffff);
	c_ipl: cover property ($rose(inbound_post_nonempty_q));
endmodule // mqcs_properties

bind mqcs_top mqcs_properties u_props (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata_q, .pci_target_hit, .pci_inbound_post, .pci_outbound_free, .pci_retry_q,
	.shell_interface_enable_q, .extended_outbound_enable_q, .inbound_post_nonempty_q,
	.outbound_free_nonempty_q);

// ===== mqcs_host_model.sv
// host side event source facing the message queue bank
`timescale 1ns/1ns
module mqcs_host_model (
	// clock and reset
	input  wire       mclk,
	input  wire       rst,
	// event requests from the bench
	input  wire [4:0] cmd,
	// registered host events
	output reg  [4:0] ev_q
);
	// events leave one edge after the request and last as many cycles as it does
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ev_q <= 5'h00;
		end else begin
			ev_q <= cmd;
		end
	end
endmodule // mqcs_host_model

// ===== test_message_queue_control_status.sv
// self-checking bench for the message queue control and status bank
`timescale 1ns/1ns
module test_message_queue_control_status;
	reg         mclk = 1'b0;
	reg         rst = 1'b1;
	reg  [11:0] reg_addr = 12'h0;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [4:0]  cmd = 5'h00;      // hit, inbound read, post, free, outbound post
	wire [4:0]  ev;
	wire [31:0] reg_rdata_q;
	wire        pci_retry_q, sh_q, ex_q, ipl_q, ofl_q;
	integer     miscompares = 0;
	integer     samples_checked = 0;
	integer     cycles = 0;
	integer     i, k;
	reg  [17:0] ptr [0:5];        // reference pointers in address order
	reg  [13:0] idx;              // reference outbound index
	reg  [7:0]  ctl;              // reference control bits, flag bits kept zero
	reg         ex_retry, ex_ipl, ex_ofl;
	reg  [13:0] m;                // stepping mask of the chosen size
	always #2 mclk = ~mclk;
	mqcs_host_model HOST (.mclk(mclk), .rst(rst), .cmd(cmd), .ev_q(ev));
	mqcs_top DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.pci_target_hit(ev[0]), .pci_inbound_read(ev[1]), .pci_inbound_post(ev[2]),
		.pci_outbound_free(ev[3]), .host_outbound_post(ev[4]), .pci_retry_q(pci_retry_q),
		.shell_interface_enable_q(sh_q), .extended_outbound_enable_q(ex_q),
		.inbound_post_nonempty_q(ipl_q), .outbound_free_nonempty_q(ofl_q));
	task check(input string what, input [31:0] exp, input [31:0] got);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	always @* m = ctl[7:5] == 3'h2 ? 14'h0ffc : ctl[7:5] == 3'h4 ? 14'h3ffc : 14'h03fc;
	////////////////////////////////////////////////////////////////////////////////
	// reference model; a software write placed last so it beats a same-edge advance
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (k = 0; k < 6; k = k + 1) ptr[k] <= 18'h0;
			idx <= 14'h0;
			ctl <= 8'h0;
			{ex_retry, ex_ipl, ex_ofl} <= 3'h0;
		end else begin
			check("retry", ex_retry, pci_retry_q);
			check("post flag", ex_ipl, ipl_q);
			check("free flag", ex_ofl, ofl_q);
			check("enables", ctl[1:0], {ex_q, sh_q});
			ex_retry <= ev[0] & ~ctl[0];
			ex_ipl <= ptr[2] != ptr[3];
			ex_ofl <= ptr[4] != ptr[5];
			if (ev[1]) ptr[0] <= ptr[0] + 18'h4;
			if (ev[2]) ptr[3] <= ptr[3] + 18'h4;
			if (ev[3]) ptr[5] <= ptr[5] + 18'h4;
			if (ev[4] && ctl[1]) idx <= (idx & ~m) | ((idx + 14'h4) & m);
			if (reg_wr && reg_addr == 12'h508) ctl <= reg_wdata[7:0] & 8'hf3;
			if (reg_wr && reg_addr >= 12'h510 && reg_addr <= 12'h524 && reg_addr[1:0] == 2'h0)
				ptr[(reg_addr - 12'h510) >> 2] <= reg_wdata[17:0] & 18'h3fffc;
			if (reg_wr && reg_addr == 12'h528) idx <= reg_wdata[13:0] & 14'h3ffc;
		end
	end
	function [31:0] exp_rd(input [11:0] a);
		exp_rd = 32'h0;
		if (a == 12'h508) exp_rd = {24'h0, ctl[7:4], ex_ofl, ex_ipl, ctl[1:0]};
		if (a >= 12'h510 && a <= 12'h524) exp_rd = {14'h0, ptr[(a - 12'h510) >> 2]};
		if ((a == 12'h518 && ptr[2] == ptr[3]) || (a == 12'h520 && ptr[4] == ptr[5]))
			if (ctl[4]) exp_rd = 32'hffffffff;
		if (a == 12'h528) exp_rd = {18'h0, idx};
	endfunction
	task wr(input [11:0] a, input [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [11:0] a);
		reg [31:0] e;
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		#1 e = exp_rd(a);
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check("read data", e, reg_rdata_q);
	endtask
	task pulses(input [4:0] c, input integer n);
		@(posedge mclk);
		cmd <= c;
		repeat (n) @(posedge mclk);
		cmd <= 5'h00;
	endtask
	task print_verdict;
		$display("counts: %0d checked, %0d mismatched", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			print_verdict;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i = $urandom(17962);
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		for (i = 0; i < 10; i = i + 1) rd(12'h508 + 4 * i);
		pulses(5'h01, 4);
		$display("test reset and retry done");
		for (i = 0; i < 4; i = i + 1) wr(12'h510 + 4 * i, 32'h100);
		for (i = 0; i < 8; i = i + 1) begin
			wr(12'h508, 32'hffffff13 | (i << 5));
			wr(12'h528, 32'h3ff8);
			pulses(5'h10, 3);
			rd(12'h528);
			rd(12'h508);
		end
		$display("test size codes done");
		for (i = 0; i < 2; i = i + 1) begin
			wr(12'h508, 32'h01 | (i << 4));
			wr(12'h518, 32'h40);
			wr(12'h51c, 32'h40);
			wr(12'h520, 32'h40);
			wr(12'h524, 32'h40);
			rd(12'h518);
			rd(12'h520);
			pulses(5'h0e, 1);
			rd(12'h518);
			rd(12'h520);
			rd(12'h510);
			rd(12'h508);
		end
		$display("test empty reads done");
		for (i = 0; i < 300; i = i + 1) begin
			@(posedge mclk);
			cmd <= $urandom;
			if ($urandom % 3 == 0) wr(12'h504 + 4 * ($urandom % 12), $urandom);
			else rd(12'h504 + 4 * ($urandom % 12));
		end
		cmd <= 5'h00;
		$display("test random traffic done");
		print_verdict;
	end
endmodule // test_message_queue_control_status
